// ==== gp_timer_pkg.sv ====
// Purpose : Shared constants for the timer, free-run and dropped-frame block
// Assumes : 125 MHz core clock, 16-bit host bus reaching 32-bit registers
// Notes   : Offsets are byte addresses of 32-bit registers
package gp_timer_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFF_TIMER_CFG   = 8'h8C;
  localparam logic [7:0]  OFF_TIMER_CNT   = 8'h90;
  localparam logic [7:0]  OFF_WORD_ORDER  = 8'h98;
  localparam logic [7:0]  OFF_FREE_RUN    = 8'h9C;
  localparam logic [7:0]  OFF_DROP_CNT    = 8'hA0;

  // Field positions and reset values
  localparam int          TIMER_EN_BIT    = 29;
  localparam int          TIMER_EN_HI_BIT = TIMER_EN_BIT - 16;
  localparam int          DROP_HALF_BIT   = 31;
  localparam logic [15:0] PRELOAD_RST     = 16'hFFFF;
  localparam logic [15:0] COUNT_RST       = 16'hFFFF;
  localparam logic [31:0] WORD_ORDER_RST  = 32'h00000000;
  localparam logic [31:0] SWAP_ALL_ONES   = 32'hFFFFFFFF;
  localparam logic [31:0] FREE_RUN_RST    = 32'h00000000;
  localparam logic [31:0] DROP_RST        = 32'h00000000;

  // Timing: core clock and the 25 MHz free-run rate
  localparam int          CLK_MHZ         = 125;
  localparam int          FR_TICK_MHZ     = 25;
  localparam int          FR_DIV          = CLK_MHZ / FR_TICK_MHZ;
  localparam logic [2:0]  FR_DIV_LAST     = 3'(FR_DIV - 1);
  localparam int          FR_CLEAR_NS     = 160;
  localparam int          FR_CLEAR_CYC    = (FR_CLEAR_NS * CLK_MHZ) / 1000;
  // Timer tick = this many free-run ticks (100 us at 25 MHz)
  localparam int          TIMER_PRESCALE  = 2500;

  // Synchroniser reset image: strobes idle high, address and data zero
  localparam logic [25:0] SYNC_RST        = {3'h7, 7'h00, 16'h0000};

endpackage

// ==== countdown_timer.sv ====
// Purpose : 16-bit down-counting interval timer with preload and wrap
// Assumes : tick is a one-cycle enable from a divider on the same clock
// Notes   : Count holds while halted; loads preload on each start
`timescale 1ns/1ps
`default_nettype none
module countdown_timer import gp_timer_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         clk,      // Core clock
  input  wire logic         rst_n,    // Synchronous reset, active low
  input  wire logic         run,      // Run enable from config
  input  wire logic [W-1:0] preload,  // Interval preload
  input  wire logic         tick,     // Count enable pulse
  output logic      [W-1:0] count,    // Live count
  output logic              expired   // One-cycle pulse at zero
);

  logic         run_q, run_d;
  logic [W-1:0] count_q, count_d;
  logic         exp_q, exp_d;

  //////////////////////////////////////////////////////////////////////////////
  // Next state: start loads, halt holds, zero wraps to preload
  always_comb begin
    run_d   = run;
    count_d = count_q;
    exp_d   = 1'b0;
    if (run && !run_q) begin
      count_d = preload;
    end else if (run && tick) begin
      if (count_q == '0) begin
        exp_d   = 1'b1;
        count_d = preload;
      end else begin
        count_d = count_q - 1'b1;
      end
    end
    // Halted: count_d keeps count_q
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q   <= 1'b0;
      count_q <= COUNT_RST[W-1:0];
      exp_q   <= 1'b0;
    end else begin
      run_q   <= run_d;
      count_q <= count_d;
      exp_q   <= exp_d;
    end
  end

  assign count   = count_q;
  assign expired = exp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_timer_halted: assert property (!run |=> $stable(count_q))
    else $error("timer count moved while halted");
  chk_timer_decrement: assert property (
    run && run_q && tick && count_q != '0 |=> count_q == $past(count_q) - 1'b1)
    else $error("timer did not decrement on tick");
  chk_timer_wrap: assert property (
    run && run_q && tick && count_q == '0 |=> exp_q && count_q == $past(preload))
    else $error("timer did not flag and reload at zero");
  chk_timer_start_load: assert property ($rose(run) |=> count_q == $past(preload))
    else $error("timer start did not load preload");
  cov_timer_expire: cover property (run_q ##1 exp_q);

endmodule
`default_nettype wire

// ==== half_read_capture.sv ====
// Purpose : Holds a 32-bit value steady across two 16-bit host reads
// Assumes : rd_hit pulses once per half-word read of the owning register
// Notes   : First read snapshots, second read returns snapshot and releases
`timescale 1ns/1ps
`default_nettype none
module half_read_capture import gp_timer_pkg::*; (
  input  wire logic        clk,         // Core clock
  input  wire logic        rst_n,       // Synchronous reset, active low
  input  wire logic [31:0] live,        // Running value
  input  wire logic        rd_hit,      // Read strobe for this register
  input  wire logic        rd_hi,       // Read targets upper half
  output logic      [15:0] half_out,    // Half-word to return
  output logic             first_read   // Pulse on snapshot-taking read
);

  logic        held_q, held_d;
  logic [31:0] cap_q, cap_d;
  logic [31:0] src;

  //////////////////////////////////////////////////////////////////////////////
  // Snapshot on first read, release on second
  always_comb begin
    held_d = held_q;
    cap_d  = cap_q;
    if (rd_hit) begin
      if (held_q) begin
        held_d = 1'b0;
      end else begin
        held_d = 1'b1;
        cap_d  = live;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_q <= 1'b0;
      cap_q  <= 32'h00000000;
    end else begin
      held_q <= held_d;
      cap_q  <= cap_d;
    end
  end

  // Second read serves the copy so both halves match
  assign src        = held_q ? cap_q : live;
  assign half_out   = rd_hi ? src[31:16] : src[15:0];
  assign first_read = rd_hit && !held_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_capture_take: assert property (
    rd_hit && !held_q |=> held_q && cap_q == $past(live))
    else $error("first read did not snapshot value");
  chk_capture_release: assert property (rd_hit && held_q |=> !held_q)
    else $error("second read did not release snapshot");
  cov_capture_pair: cover property (rd_hit && !held_q ##[1:40] rd_hit && held_q);

endmodule
`default_nettype wire

// ==== gp_timer_counters.sv ====
// Purpose : Host-visible timer, 25 MHz free-run counter, dropped-frame tally
//           and host word-order control behind the 16-bit host bus
// Assumes : Host pins are asynchronous; strobes held for several core clocks
// Notes   : Strobes are edge based, so a long strobe makes one access only
// Operation
// - Writing one to the run bit starts the interval timer.
// - Run bit zero keeps the interval timer halted.
// - Run bit falling forces the preload field to all ones.
// - Preload is 16-bit read/write, resets to all ones, loads the timer.
// - Count register low half shows live timer value, all ones at reset.
// - Timer raises interrupt events at intervals set by the preload.
// - Word-order not all ones: address bit one selects upper half.
// - Word-order all ones: address bit one selects lower half.
// - Network-side FIFO half-word order never depends on the swap setting.
// - 32-bit free-run counter starts at zero, counts each 25 MHz cycle.
// - Free-run counter rolls over to zero at maximum and continues.
// - First half-word read captures the whole free-run count.
// - Free-run counter may need up to 160 ns to clear after reset.
// - Free-run counter counts in every power management state.
// - Dropped-frame counter increments on every discarded receive frame.
// - First half-word read of the dropped-frame register returns count and clears it.
// - Dropped-frame counter top bit rising raises a halfway event.
`timescale 1ns/1ps
`default_nettype none
module gp_timer_counters import gp_timer_pkg::*; #(
  parameter int PRESCALE = TIMER_PRESCALE
) (
  input  wire logic        clk,                // Core clock, 125 MHz
  input  wire logic        rst_n,              // Synchronous reset, active low
  input  wire logic [7:1]  host_addr,          // Host half-word address
  input  wire logic        host_cs_n,          // Chip select, active low
  input  wire logic        host_rd_n,          // Read strobe, active low
  input  wire logic        host_wr_n,          // Write strobe, active low
  input  wire logic [15:0] host_data_in,       // Host write data
  output logic      [15:0] host_data_out,      // Host read data
  output logic             host_data_oe,       // Drive data bus, high = drive
  input  wire logic        rx_frame_dropped,   // Pulse per discarded frame
  output logic             timer_event,        // Timer interval pulse
  output logic             drop_halfway_event  // Drop tally crossed midpoint
);

  //////////////////////////////////////////////////////////////////////////////
  // Host pin synchroniser and strobe edges
  logic [25:0] sync1_q, sync2_q;
  logic        rd_act_q, wr_act_q;
  logic        s_cs_n, s_rd_n, s_wr_n;
  logic [7:1]  s_addr;
  logic [15:0] s_data;
  logic        rd_act, wr_act, rd_start, wr_start;

  // Two flops per pin; only sync2 is read by logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q  <= SYNC_RST;
      sync2_q  <= SYNC_RST;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      sync1_q  <= {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in};
      sync2_q  <= sync1_q;
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  assign {s_cs_n, s_rd_n, s_wr_n, s_addr, s_data} = sync2_q;
  assign rd_act   = !s_cs_n && !s_rd_n;
  assign wr_act   = !s_cs_n && !s_wr_n;
  assign rd_start = rd_act && !rd_act_q;
  assign wr_start = wr_act && !wr_act_q;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and half-word mapping
  logic [7:0]  reg_off;
  logic        hi_sel;
  logic [31:0] word_order_q, word_order_d;

  assign reg_off = {s_addr[7:2], 2'b00};
  // Only the host side is swapped; network ordering is fixed elsewhere
  assign hi_sel  = (word_order_q == SWAP_ALL_ONES) ? !s_addr[1] : s_addr[1];

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers: run bit, preload, word order
  logic        run_q, run_d;
  logic [15:0] preload_q, preload_d;

  always_comb begin
    run_d        = run_q;
    preload_d    = preload_q;
    word_order_d = word_order_q;
    if (wr_start) begin
      unique case (reg_off)
        OFF_TIMER_CFG: begin
          if (hi_sel) begin
            run_d = s_data[TIMER_EN_HI_BIT];
          end else begin
            preload_d = s_data;
          end
        end
        OFF_WORD_ORDER: begin
          if (hi_sel) begin
            word_order_d[31:16] = s_data;
          end else begin
            word_order_d[15:0] = s_data;
          end
        end
        default: ;
      endcase
    end
    // Stop wins over a preload written in the same access
    if (run_q && !run_d) begin
      preload_d = PRELOAD_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q        <= 1'b0;
      preload_q    <= PRELOAD_RST;
      word_order_q <= WORD_ORDER_RST;
    end else begin
      run_q        <= run_d;
      preload_q    <= preload_d;
      word_order_q <= word_order_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz enable, free-run counter and timer prescaler
  logic [2:0]  div_q, div_d;
  logic [31:0] fr_q, fr_d;
  logic [11:0] pre_q, pre_d;
  logic        fr_tick, timer_tick;

  assign fr_tick    = (div_q == FR_DIV_LAST);
  assign timer_tick = fr_tick && (pre_q == 12'(PRESCALE - 1));

  // No power-state input: the counter never gates off
  always_comb begin
    div_d = fr_tick ? 3'h0 : div_q + 3'h1;
    fr_d  = fr_tick ? fr_q + 32'h00000001 : fr_q;
    pre_d = pre_q;
    if (fr_tick) begin
      pre_d = timer_tick ? 12'h000 : pre_q + 12'h001;
    end
  end

  // Clears at the first edge of reset, well inside the allowed window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      fr_q  <= FREE_RUN_RST;
      pre_q <= 12'h000;
    end else begin
      div_q <= div_d;
      fr_q  <= fr_d;
      pre_q <= pre_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interval timer
  logic [15:0] timer_count;

  countdown_timer #(
    .W (16)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (run_q),
    .preload (preload_q),
    .tick    (timer_tick),
    .count   (timer_count),
    .expired (timer_event)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read snapshots for the two 32-bit counters
  logic        fr_rd_hit, drop_rd_hit, drop_clear;
  logic [15:0] fr_half, drop_half;
  logic [31:0] drop_q, drop_d;

  assign fr_rd_hit   = rd_start && (reg_off == OFF_FREE_RUN);
  assign drop_rd_hit = rd_start && (reg_off == OFF_DROP_CNT);

  half_read_capture u_fr_cap (
    .clk        (clk),
    .rst_n      (rst_n),
    .live       (fr_q),
    .rd_hit     (fr_rd_hit),
    .rd_hi      (hi_sel),
    .half_out   (fr_half),
    .first_read ()
  );

  // Drop tally clears on the snapshot read so the pair stays coherent
  half_read_capture u_drop_cap (
    .clk        (clk),
    .rst_n      (rst_n),
    .live       (drop_q),
    .rd_hit     (drop_rd_hit),
    .rd_hi      (hi_sel),
    .half_out   (drop_half),
    .first_read (drop_clear)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Dropped-frame tally; a drop in the clearing cycle is kept
  logic halfway_q, halfway_d;

  always_comb begin
    drop_d = drop_q;
    if (drop_clear) begin
      drop_d = DROP_RST;
    end
    if (rx_frame_dropped) begin
      drop_d = drop_d + 32'h00000001;
    end
    halfway_d = !drop_q[DROP_HALF_BIT] && drop_d[DROP_HALF_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drop_q    <= DROP_RST;
      halfway_q <= 1'b0;
    end else begin
      drop_q    <= drop_d;
      halfway_q <= halfway_d;
    end
  end

  assign drop_halfway_event = halfway_q;

  //////////////////////////////////////////////////////////////////////////////
  // Read data register; unmapped offsets read zero
  logic [15:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (rd_start) begin
      unique case (reg_off)
        OFF_TIMER_CFG:  rdata_d = hi_sel ? 16'(32'(run_q) << TIMER_EN_HI_BIT) : preload_q;
        OFF_TIMER_CNT:  rdata_d = hi_sel ? 16'h0000 : timer_count;
        OFF_WORD_ORDER: rdata_d = hi_sel ? word_order_q[31:16] : word_order_q[15:0];
        OFF_FREE_RUN:   rdata_d = fr_half;
        OFF_DROP_CNT:   rdata_d = drop_half;
        default:        rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign host_data_out = rdata_q;
  assign host_data_oe  = rd_act && rd_act_q;        // Drive once data is valid

  // Helper for the clear check: drop arriving in the clearing cycle
  logic rx_frame_dropped_past;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_preload_on_stop: assert property ($fell(run_q) |-> preload_q == PRELOAD_RST)
    else $error("preload not forced to all ones on stop");
  chk_fr_tick_rate: assert property (fr_tick |=> !fr_tick [*4] ##1 fr_tick)
    else $error("free-run tick not every fifth clock");
  chk_fr_increment: assert property (fr_tick |=> fr_q == $past(fr_q) + 32'h00000001)
    else $error("free-run counter did not step or wrap");
  chk_fr_hold: assert property (!fr_tick |=> $stable(fr_q))
    else $error("free-run counter moved between ticks");
  chk_drop_count: assert property (
    rx_frame_dropped && !drop_clear |=> drop_q == $past(drop_q) + 32'h00000001)
    else $error("dropped frame not counted");
  chk_drop_clear: assert property (drop_clear |=> drop_q == 32'(rx_frame_dropped_past))
    else $error("read did not clear drop tally");
  chk_drop_halfway: assert property (
    halfway_q |-> drop_q[DROP_HALF_BIT] && !$past(drop_q[DROP_HALF_BIT]))
    else $error("halfway event without top bit rising");
  chk_swap_map: assert property (
    rd_start && word_order_q != SWAP_ALL_ONES |-> hi_sel == s_addr[1])
    else $error("default word order mapped wrong half");
  chk_swap_invert: assert property (
    rd_start && word_order_q == SWAP_ALL_ONES |-> hi_sel == !s_addr[1])
    else $error("swapped word order mapped wrong half");
  cov_timer_event: cover property (run_q ##[1:1000] timer_event);
  cov_drop_read_pair: cover property (drop_clear ##[1:40] drop_rd_hit);
  cov_fr_read: cover property (fr_rd_hit);

  // Registers the drop pulse for the clear check above
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_frame_dropped_past <= 1'b0;
    end else begin
      rx_frame_dropped_past <= rx_frame_dropped;
    end
  end

endmodule
`default_nettype wire

// ==== host_cpu_model.sv ====
// Purpose : Host CPU model on the 16-bit asynchronous register bus
// Assumes : Signals change just after a rising edge of clk
// Notes   : Released address and write lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input  wire logic        clk,   // Core clock
  output logic      [7:1]  addr,  // Half-word address
  output logic             cs_n,  // Chip select, active low
  output logic             rd_n,  // Read strobe, active low
  output logic             wr_n,  // Write strobe, active low
  output logic      [15:0] wdata, // Write data
  input  wire logic [15:0] rdata, // Read data
  input  wire logic        oe,    // Device drives the bus
  output logic             hang   // Read answer never came
);
  // Idle bus at time zero
  initial begin
    addr = 7'h00;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    wdata = 16'h0000;
    hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // Writes get no answer, so the strobe is held four clocks
  task automatic wr(input logic [7:0] off, input logic hi, input logic [15:0] d);
    @(posedge clk);
    addr <= {off[7:2], hi};
    wdata <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    addr <= ~{off[7:2], hi};
    wdata <= ~d; // Released lines must not keep the old value
    repeat (5) @(posedge clk);
  endtask

  // Read holds the strobe until oe is sampled high, then releases
  task automatic rd(input logic [7:0] off, input logic hi, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {off[7:2], hi};
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (oe !== 1'b1 && n < 20);
    d = rdata;
    hang = (oe !== 1'b1);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    addr <= ~{off[7:2], hi}; // Stale address must not look like a new access
    repeat (6) @(posedge clk); // Gap lets the synced strobe go idle
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose : Self-checking bench for the timer and counter block
// Assumes : Small prescale so timer intervals stay short
// Notes   : Halfway event and counter wrap are too long to reach here
`timescale 1ns/1ps
`default_nettype none
module testbench import gp_timer_pkg::*; ;
  localparam int PS = 2;
  logic        clk;
  logic        rst_n;
  logic        rx_frame_dropped;
  logic [7:1]  host_addr;
  logic        host_cs_n;
  logic        host_rd_n;
  logic        host_wr_n;
  logic [15:0] host_data_in;
  logic [15:0] host_data_out;
  logic        host_data_oe;
  logic        timer_event;
  logic        drop_halfway_event;
  logic        hang;
  int          err_count;
  int          check_count;
  int          cyc;
  logic        halfway_seen = 1'b0;

  gp_timer_counters #(.PRESCALE(PS)) i_gp_timer_counters (
    .clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .rx_frame_dropped(rx_frame_dropped), .timer_event(timer_event),
    .drop_halfway_event(drop_halfway_event));
  host_cpu_model i_host_cpu_model (
    .clk(clk), .addr(host_addr), .cs_n(host_cs_n), .rd_n(host_rd_n),
    .wr_n(host_wr_n), .wdata(host_data_in), .rdata(host_data_out),
    .oe(host_data_oe), .hang(hang));

  // Clock, cycle count and hang cut-off
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Sticky record of any halfway pulse; drop counts here stay far below midpoint
  always @(posedge clk) begin
    if (rst_n === 1'b1 && drop_halfway_event !== 1'b0) begin
      halfway_seen <= 1'b1;
    end
  end
  always @(posedge hang) begin
    err_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] o, input logic h, input logic [15:0] d);
    i_host_cpu_model.wr(o, h, d);
  endtask
  task automatic rd(input logic [7:0] o, input logic h, output logic [15:0] d);
    i_host_cpu_model.rd(o, h, d);
  endtask
  task automatic rc(input logic [7:0] o, input logic h, input logic [15:0] e, input string m);
    logic [15:0] d;
    rd(o, h, d);
    check(d, e, m);
  endtask
  // Bounded wait for one timer pulse, returns its cycle
  task automatic wait_event(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timer_event !== 1'b1 && n < 200);
    t = cyc;
    if (timer_event !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic drops(input int n);
    repeat (n) begin
      @(posedge clk);
      rx_frame_dropped <= 1'b1;
    end
    @(posedge clk);
    rx_frame_dropped <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic reset_values();
    logic [15:0] d;
    rd(OFF_FREE_RUN, 1'b0, d);
    check(d < 16'h0010, 1, "free run not cleared");
    rc(OFF_FREE_RUN, 1'b1, 16'h0000, "free run high");
    rc(OFF_TIMER_CFG, 1'b0, PRELOAD_RST, "preload reset");
    rc(OFF_TIMER_CFG, 1'b1, 16'h0000, "run reset");
    rc(OFF_TIMER_CNT, 1'b0, COUNT_RST, "count reset");
    rc(OFF_WORD_ORDER, 1'b0, 16'h0000, "order reset");
    rc(8'h80, 1'b0, 16'h0000, "unmapped");
  endtask
  // Preload 3 gives four ticks between pulses
  task automatic timer_run();
    int t0;
    int t1;
    logic [15:0] a;
    logic [15:0] b;
    wr(OFF_TIMER_CFG, 1'b0, 16'h0003);
    wr(OFF_TIMER_CNT, 1'b0, 16'h1234);
    rc(OFF_TIMER_CNT, 1'b0, COUNT_RST, "count not read only");
    wr(OFF_TIMER_CFG, 1'b1, 16'(1 << TIMER_EN_HI_BIT));
    rd(OFF_TIMER_CNT, 1'b0, a);
    check(a <= 16'h0003, 1, "count not loaded");
    wait_event(t0);
    wait_event(t1);
    check(t1 - t0, 4 * PS * FR_DIV, "interval");
    wr(OFF_TIMER_CFG, 1'b1, 16'h0000);
    rc(OFF_TIMER_CFG, 1'b0, PRELOAD_RST, "preload not forced");
    rd(OFF_TIMER_CNT, 1'b0, a);
    repeat (60) @(posedge clk);
    rd(OFF_TIMER_CNT, 1'b0, b);
    check(b, a, "halted count moved");
  endtask
  task automatic word_swap();
    wr(OFF_WORD_ORDER, 1'b0, 16'hFFFF);
    wr(OFF_WORD_ORDER, 1'b1, 16'hFFFF);
    wr(OFF_TIMER_CFG, 1'b1, 16'h00A5);
    rc(OFF_TIMER_CFG, 1'b1, 16'h00A5, "swap low");
    rc(OFF_TIMER_CFG, 1'b0, 16'h0000, "swap high");
    wr(OFF_WORD_ORDER, 1'b1, 16'h0000);
    rc(OFF_TIMER_CFG, 1'b0, 16'h00A5, "plain low");
    rc(OFF_WORD_ORDER, 1'b1, 16'hFFFF, "plain high");
  endtask
  // Count grows by elapsed clocks over five, one tick of slack
  task automatic free_run();
    logic [15:0] l1;
    logic [15:0] h1;
    logic [15:0] l2;
    logic [15:0] h2;
    int c1;
    int e;
    logic [31:0] dv;
    rd(OFF_FREE_RUN, 1'b0, l1);
    c1 = cyc;
    rd(OFF_FREE_RUN, 1'b1, h1);
    repeat (300) @(posedge clk);
    rd(OFF_FREE_RUN, 1'b0, l2);
    e = (cyc - c1) / FR_DIV;
    rd(OFF_FREE_RUN, 1'b1, h2);
    dv = {h2, l2} - {h1, l1};
    check(dv >= e - 1 && dv <= e + 1, 1, "free run rate");
  endtask
  // A drop between halves lands after the clear
  task automatic drop_count();
    drops(5);
    rc(OFF_DROP_CNT, 1'b0, 16'h0005, "drop tally");
    drops(1);
    rc(OFF_DROP_CNT, 1'b1, 16'h0000, "drop snapshot");
    rc(OFF_DROP_CNT, 1'b0, 16'h0001, "clear on read");
    rc(OFF_DROP_CNT, 1'b1, 16'h0000, "drop high");
    rc(OFF_DROP_CNT, 1'b0, 16'h0000, "drop cleared");
    check(halfway_seen, 1'b0, "halfway event without crossing");
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rx_frame_dropped = 1'b0;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    timer_run();
    word_swap();
    free_run();
    drop_count();
    tally_and_finish();
  end
endmodule
`default_nettype wire
